// ==== design/ccdo_consts.svh ====
// constants for the clear, decrement and complement execute block
`ifndef CCDO_CONSTS_SVH
`define CCDO_CONSTS_SVH
`define CCDO_OP_CLEAR_ACC    14'h0103
`define CCDO_OP_CLEAR_WDOG   14'h0064
`define CCDO_OPC_DEC_FILE    6'h03
`define CCDO_OPC_COMP_FILE   6'h09
`define CCDO_OPC_MSB         13
`define CCDO_OPC_LSB         8
`define CCDO_DEST_BIT        7
`define CCDO_ADDR_MSB        6
`define CCDO_ACC_RST         8'h00
`define CCDO_WDOG_RST        8'h00
`define CCDO_PRESC_RST       8'h00
`define CCDO_ZERO_RST        1'b0
`define CCDO_STAT_RST        1'b1
`endif

// ==== design/ccdo_pkg.sv ====
// types for the clear, decrement and complement execute block
package ccdo_pkg;
    typedef enum logic [2:0] {
        CCDO_NONE  = 3'b000,
        CCDO_CLRA  = 3'b001,
        CCDO_CLRWD = 3'b010,
        CCDO_DEC   = 3'b011,
        CCDO_COMP  = 3'b100
    } ccdo_op_type;
endpackage

// ==== design/ccdo_exec.sv ====
// execute logic for clear accumulator, clear watchdog, decrement and complement
`timescale 1ns/1ps
`include "ccdo_consts.svh"

module ccdo_exec
    import ccdo_pkg::*;
#(
    parameter int DATA_W  = 8,
    parameter int ADDR_W  = 7,
    parameter int WDOG_W  = 8,
    parameter int PRESC_W = 8
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // instruction
    input  wire logic                instr_valid,
    input  wire logic [13:0]         instr,
    // file register read data for the addressed location
    input  wire logic [DATA_W-1:0]   file_rdata,
    // watchdog ticks
    input  wire logic                presc_tick,
    input  wire logic                wdog_tick,
    // file register write port
    output logic                     file_we_q,
    output logic [ADDR_W-1:0]        file_waddr_q,
    output logic [DATA_W-1:0]        file_wdata_q,
    // core state
    output logic [DATA_W-1:0]        acc_q,
    output logic                     zero_flag_q,
    output logic                     timeout_status_bit_q,
    output logic                     powerdown_status_bit_q,
    output logic [WDOG_W-1:0]        watchdog_counter_q,
    output logic [PRESC_W-1:0]       presc_q
);

    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    if (DATA_W != 8 || ADDR_W != 7 || WDOG_W < 1 || PRESC_W < 1) begin : g_param_check
        $error("ccdo_exec: unsupported parameter values");
    end

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic ccdo_op_type decode_op(input logic [13:0] iw);
        if (iw == `CCDO_OP_CLEAR_ACC) begin
            decode_op = CCDO_CLRA;
        end else if (iw == `CCDO_OP_CLEAR_WDOG) begin
            decode_op = CCDO_CLRWD;
        end else if (iw[`CCDO_OPC_MSB:`CCDO_OPC_LSB] == `CCDO_OPC_DEC_FILE) begin
            decode_op = CCDO_DEC;
        end else if (iw[`CCDO_OPC_MSB:`CCDO_OPC_LSB] == `CCDO_OPC_COMP_FILE) begin
            decode_op = CCDO_COMP;
        end else begin
            decode_op = CCDO_NONE;
        end
    endfunction

    function automatic logic is_file_op(input ccdo_op_type o);
        is_file_op = (o == CCDO_DEC) || (o == CCDO_COMP);
    endfunction

    ccdo_op_type              op;
    logic [DATA_W-1:0]        result;
    logic                     dest;

    always_comb begin
        op     = instr_valid ? decode_op(instr) : CCDO_NONE;
        dest   = instr[`CCDO_DEST_BIT];
        result = '0;
        case (op)
            CCDO_DEC:  result = file_rdata - DATA_W'(1);
            CCDO_COMP: result = ~file_rdata;
            default:   result = '0;
        endcase
    end

    // ----------------------------------------
    // accumulator and zero flag
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q       <= `CCDO_ACC_RST;
            zero_flag_q <= `CCDO_ZERO_RST;
        end else begin
            case (op)
                CCDO_CLRA: begin
                    acc_q       <= `CCDO_ACC_RST;
                    zero_flag_q <= 1'b1;
                end
                CCDO_DEC, CCDO_COMP: begin
                    if (!dest) begin
                        acc_q <= result;
                    end
                    zero_flag_q <= (result == '0);
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // file write back
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            file_we_q    <= 1'b0;
            file_waddr_q <= '0;
            file_wdata_q <= '0;
        end else begin
            file_we_q    <= is_file_op(op) && dest;
            file_waddr_q <= instr[`CCDO_ADDR_MSB:0];
            file_wdata_q <= result;
        end
    end

    // ----------------------------------------
    // watchdog and status bits
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            watchdog_counter_q <= WDOG_W'(`CCDO_WDOG_RST);
            presc_q            <= PRESC_W'(`CCDO_PRESC_RST);
        end else if (op == CCDO_CLRWD) begin
            watchdog_counter_q <= WDOG_W'(`CCDO_WDOG_RST);
            presc_q            <= PRESC_W'(`CCDO_PRESC_RST);
        end else begin
            if (presc_tick) begin
                presc_q <= presc_q + PRESC_W'(1);
            end
            if (wdog_tick) begin
                watchdog_counter_q <= watchdog_counter_q + WDOG_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            timeout_status_bit_q   <= `CCDO_STAT_RST;
            powerdown_status_bit_q <= `CCDO_STAT_RST;
        end else if (op == CCDO_CLRWD) begin
            timeout_status_bit_q   <= 1'b1;
            powerdown_status_bit_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_clra_zero: assert property (@(posedge clk) disable iff (rst)
        instr_valid && instr == `CCDO_OP_CLEAR_ACC |=> acc_q == '0 && zero_flag_q)
        else $error("clear accumulator did not zero acc and set zero");
    a_clrwd_cnt: assert property (@(posedge clk) disable iff (rst)
        instr_valid && instr == `CCDO_OP_CLEAR_WDOG |=>
        watchdog_counter_q == '0 && presc_q == '0)
        else $error("clear watchdog did not zero counters");
    a_clrwd_stat: assert property (@(posedge clk) disable iff (rst)
        instr_valid && instr == `CCDO_OP_CLEAR_WDOG |=>
        timeout_status_bit_q && powerdown_status_bit_q && $stable(zero_flag_q) && $stable(acc_q))
        else $error("clear watchdog status effect wrong");
    a_wdog_count: assert property (@(posedge clk) disable iff (rst)
        op != CCDO_CLRWD && wdog_tick |=>
        watchdog_counter_q == $past(watchdog_counter_q) + WDOG_W'(1))
        else $error("watchdog counter did not count");
    a_presc_count: assert property (@(posedge clk) disable iff (rst)
        op != CCDO_CLRWD && presc_tick |=>
        presc_q == $past(presc_q) + PRESC_W'(1))
        else $error("prescaler did not count");

    // ----------------------------------------
    // assertions: file ops and idle
    // ----------------------------------------
    a_dec_value: assert property (@(posedge clk) disable iff (rst)
        op == CCDO_DEC |=> zero_flag_q == ($past(file_rdata) == 8'h01))
        else $error("decrement zero flag wrong");
    a_comp_value: assert property (@(posedge clk) disable iff (rst)
        op == CCDO_COMP && !dest |=> acc_q == ~$past(file_rdata) && zero_flag_q == (acc_q == '0))
        else $error("complement result wrong");
    a_dest_file: assert property (@(posedge clk) disable iff (rst)
        (op == CCDO_DEC || op == CCDO_COMP) && dest |=> file_we_q && $stable(acc_q))
        else $error("destination one did not write file");
    a_dest_acc: assert property (@(posedge clk) disable iff (rst)
        (op == CCDO_DEC || op == CCDO_COMP) && !dest |=> !file_we_q)
        else $error("destination zero wrote file");
    a_addr_field: assert property (@(posedge clk) disable iff (rst)
        op == CCDO_DEC && dest |=> file_waddr_q == $past(instr[6:0])
        && file_wdata_q == $past(file_rdata) - 8'h01)
        else $error("file write address or data wrong");
    a_dec_acc: assert property (@(posedge clk) disable iff (rst)
        op == CCDO_DEC && !dest |=> acc_q == $past(file_rdata) - 8'h01)
        else $error("decrement to accumulator wrong");
    a_comp_file: assert property (@(posedge clk) disable iff (rst)
        op == CCDO_COMP && dest |=> file_we_q && file_wdata_q == ~$past(file_rdata))
        else $error("complement write back wrong");
    a_comp_zero: assert property (@(posedge clk) disable iff (rst)
        op == CCDO_COMP |=> zero_flag_q == ($past(file_rdata) == 8'hff))
        else $error("complement zero flag wrong");
    a_we_only_file: assert property (@(posedge clk) disable iff (rst)
        !(is_file_op(op) && dest) |=> !file_we_q)
        else $error("file write without file destination");
    a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
        op == CCDO_NONE |=> $stable(acc_q) && $stable(zero_flag_q))
        else $error("undecoded word changed accumulator or zero flag");

    // ----------------------------------------
    // cover points
    // ----------------------------------------
    c_clra:  cover property (@(posedge clk) disable iff (rst) op == CCDO_CLRA);
    c_clrwd: cover property (@(posedge clk) disable iff (rst) op == CCDO_CLRWD);
    c_dec_z: cover property (@(posedge clk) disable iff (rst) op == CCDO_DEC && result == '0);
    c_comp_f: cover property (@(posedge clk) disable iff (rst) op == CCDO_COMP && dest);
    c_dec_a: cover property (@(posedge clk) disable iff (rst) op == CCDO_DEC && !dest);

endmodule // ccdo_exec

// ==== verif/ccdo_exec_bench.sv ====
// self-checking bench for the clear, decrement and complement execute block
`timescale 1ns/1ps
`include "ccdo_consts.svh"

module ccdo_exec_bench;
    import ccdo_pkg::*;
    // clock and reset
    logic        clk;
    logic        rst;
    // stimulus
    logic        instr_valid;
    logic [13:0] instr;
    logic [7:0]  file_rdata;
    logic        presc_tick;
    logic        wdog_tick;
    // observed
    logic        file_we_q;
    logic [6:0]  file_waddr_q;
    logic [7:0]  file_wdata_q;
    logic [7:0]  acc_q;
    logic        zero_flag_q;
    logic        timeout_status_bit_q;
    logic        powerdown_status_bit_q;
    logic [7:0]  watchdog_counter_q;
    logic [7:0]  presc_q;
    int          num_errors = 0;
    int          n_compared = 0;

    ccdo_exec i_dut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .file_rdata(file_rdata), .presc_tick(presc_tick), .wdog_tick(wdog_tick),
        .file_we_q(file_we_q), .file_waddr_q(file_waddr_q), .file_wdata_q(file_wdata_q),
        .acc_q(acc_q), .zero_flag_q(zero_flag_q),
        .timeout_status_bit_q(timeout_status_bit_q),
        .powerdown_status_bit_q(powerdown_status_bit_q),
        .watchdog_counter_q(watchdog_counter_q), .presc_q(presc_q));

    always #25 clk = ~clk;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic exec(input logic [13:0] i, input logic [7:0] d);
        instr_valid = 1'b1;
        instr       = i;
        file_rdata  = d;
        @(posedge clk);
        #1;
    endtask

    task automatic idle(input logic tick);
        instr_valid = 1'b0;
        presc_tick  = tick;
        wdog_tick   = tick;
        @(posedge clk);
        #1;
    endtask

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_comp_then_clear;
        exec(14'h0905, 8'h13);
        check(acc_q, 16'h00ec);
        check({file_we_q, zero_flag_q}, 16'h0000);
        exec(`CCDO_OP_CLEAR_ACC, 8'h5a);
        check({acc_q, 7'h00, zero_flag_q}, 16'h0001);
        idle(1'b0);
        $display("test comp_then_clear done");
    endtask

    task automatic t_clear_wdog;
        exec(14'h0305, 8'h05);
        repeat (3) idle(1'b1);
        check({watchdog_counter_q, presc_q}, 16'h0303);
        exec(`CCDO_OP_CLEAR_WDOG, 8'h00);
        check({watchdog_counter_q, presc_q}, 16'h0000);
        check({timeout_status_bit_q, powerdown_status_bit_q}, 16'h0003);
        check({acc_q, 7'h00, zero_flag_q}, 16'h0400);
        idle(1'b0);
        $display("test clear_wdog done");
    endtask

    task automatic t_dec_back_to_back;
        exec(14'h03ff, 8'h01);
        check({file_we_q, file_waddr_q, file_wdata_q}, 16'hff00);
        check({acc_q, 7'h00, zero_flag_q}, 16'h0401);
        exec(14'h0300, 8'h00);
        check({acc_q, 7'h00, zero_flag_q}, 16'hff00);
        check(file_we_q, 16'h0000);
        idle(1'b0);
        $display("test dec_back_to_back done");
    endtask

    task automatic t_comp_write_back;
        exec(14'h09aa, 8'hff);
        check({file_we_q, file_waddr_q, file_wdata_q}, 16'haa00);
        check({acc_q, 7'h00, zero_flag_q}, 16'hff01);
        exec(14'h0000, 8'h00);
        check({file_we_q, acc_q, zero_flag_q}, 16'h01ff);
        idle(1'b0);
        $display("test comp_write_back done");
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        instr_valid = 1'b0;
        instr = 14'h0000;
        file_rdata = 8'h00;
        presc_tick = 1'b0;
        wdog_tick = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        t_comp_then_clear();
        t_clear_wdog();
        t_dec_back_to_back();
        t_comp_write_back();
        end_of_test();
    end

    initial begin
        #(2000 * 50);
        num_errors++;
        end_of_test();
    end
endmodule // ccdo_exec_bench
